// [sepc_regs.svh]
// Constants of the serial command and write-protection front end.
// Assumes inclusion by bare name from the decoder and checker files.
`ifndef SEPC_REGS_SVH
`define SEPC_REGS_SVH

// Opcodes with the don't-care bit cleared, and the mask that clears it.
`define SEPC_OP_KEY_MASK 8'hF7
`define SEPC_OP_SET_WL 8'h06
`define SEPC_OP_CLR_WL 8'h04
`define SEPC_OP_SR_RD 8'h05
`define SEPC_OP_SR_WR 8'h01
`define SEPC_OP_ARR_RD 8'h03
`define SEPC_OP_ARR_WR 8'h02
`define SEPC_OP_ID_RD 8'h83
`define SEPC_OP_ID_WR 8'h82

// Status byte field positions.
`define SEPC_SR_BUSY 0
`define SEPC_SR_WEN 1
`define SEPC_SR_BP_LO 2
`define SEPC_SR_BP_HI 3
`define SEPC_SR_HW_PROTECT_ENABLE_BIT 7
`define SEPC_SR_ALL_BUSY 8'hFF

// Address and data key positions and protected range bases.
`define SEPC_ADDR_SEL_BIT 7
`define SEPC_LOCK_KEY_BIT 1
`define SEPC_QTR_BASE 10'h300
`define SEPC_HALF_BASE 10'h200

// Reset and delivered-state values.
`define SEPC_BP_RESET 2'h0
`define SEPC_HW_PROTECT_ENABLE_BIT_RESET 1'h0
`define SEPC_WEN_RESET 1'h0

`endif

// [sepc_pkg.sv]
// Types shared by the serial command and write-protection front end.
// Assumes the constants header is on the include path.
package sepc_pkg;

    // Frame sequencer states.
    typedef enum logic [2:0] {
        SEPC_ST_OPCODE = 3'h0,
        SEPC_ST_NOARG = 3'h1,
        SEPC_ST_ADDR = 3'h2,
        SEPC_ST_IN = 3'h3,
        SEPC_ST_OUT = 3'h4,
        SEPC_ST_IGNORE = 3'h5
    } sepc_state_type;

    // Kind of self-timed programming cycle handed to the storage core.
    typedef enum logic [1:0] {
        SEPC_PK_ARRAY = 2'h0,
        SEPC_PK_STATUS = 2'h1,
        SEPC_PK_IDPAGE = 2'h2,
        SEPC_PK_LOCK = 2'h3
    } sepc_kind_type;

    // Source of the byte shifted out.
    typedef enum logic [1:0] {
        SEPC_SRC_STATUS = 2'h0,
        SEPC_SRC_MEM = 2'h1,
        SEPC_SRC_ID = 2'h2,
        SEPC_SRC_LOCK = 2'h3
    } sepc_src_type;

endpackage : sepc_pkg

// [sepc_pin_sync.sv]
// Two-stage synchronisers for the serial pins.
// Assumes every input is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sepc_pin_sync (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] pin_in,
    input wire logic [3:0] pin_rst_val,
    output logic [3:0] pin_sync_ff
);
    logic [3:0] meta_ff;

    // One flop pair per pin; only the second stage is read outside.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_bit
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    meta_ff[gi] <= 1'b1;
                    pin_sync_ff[gi] <= 1'b1;
                end else begin
                    meta_ff[gi] <= pin_in[gi];
                    pin_sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate
endmodule : sepc_pin_sync
`default_nettype wire

// [sepc_cmd_protect.sv]
// Serial command decoder and write-protection logic of a serial EEPROM.
// Assumes the storage core answers on clk_sys and serial pins are async.
`timescale 1ns/1ps
`default_nettype none
`include "sepc_regs.svh"
module sepc_cmd_protect
    import sepc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    input wire logic wp_n_pin,
    input wire logic [7:0] mem_rd_data,
    input wire logic [7:0] id_rd_data,
    input wire logic id_locked,
    input wire logic prog_done,
    output logic so_ff,
    output logic so_oe_ff,
    output logic [9:0] mem_addr_ff,
    output logic mem_rd_ff,
    output logic mem_wr_ff,
    output logic [4:0] id_addr_ff,
    output logic id_rd_ff,
    output logic id_wr_ff,
    output logic [7:0] wr_data_ff,
    output logic prog_start_ff,
    output logic [1:0] prog_kind_ff,
    output logic busy_ff,
    output logic wen_ff,
    output logic [1:0] bp_ff,
    output logic hw_protect_enable_bit_ff
);

    logic [3:0] pin_sync;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic wp_n_s;
    logic sck_d_ff;
    logic cs_d_ff;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    sepc_state_type state_ff;
    sepc_state_type nxt_state;
    sepc_state_type op_state;
    logic [2:0] bit_cnt_ff;
    logic [7:0] rx_ff;
    logic [7:0] rx_byte;
    logic byte_done;
    logic [7:0] op_key;
    logic [7:0] opcode_ff;
    logic [7:0] addr_hi_ff;
    logic addr_hi_done_ff;
    logic addr_done;
    logic sel_lock_ff;
    logic [9:0] ptr_ff;
    logic [9:0] nxt_ptr;
    logic is_id_op;
    sepc_src_type out_src;
    logic out_load;
    logic [7:0] status_byte;
    logic [7:0] load_byte;
    logic [7:0] tx_ff;
    logic in_byte;
    logic got_data_ff;
    logic lock_key_ff;
    logic [7:0] sr_data_ff;
    logic [7:0] pend_sr_ff;
    logic hw_prot;
    logic noarg_end;
    logic commit_frame;
    logic commit_go;
    sepc_kind_type commit_kind;
    logic cycle_end;

    // Pins cross into clk_sys before anything looks at them.
    sepc_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin_in({wp_n_pin, si_pin, sck_pin, cs_n_pin}),
        .pin_rst_val(4'hF),
        .pin_sync_ff(pin_sync)
    );
    assign cs_n_s = pin_sync[0];
    assign sck_s = pin_sync[1];
    assign si_s = pin_sync[2];
    assign wp_n_s = pin_sync[3];

    // Edge detectors on the synchronised serial clock and select.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sck_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
        end else begin
            sck_d_ff <= sck_s;
            cs_d_ff <= cs_n_s;
        end
    end

    // Clock edges only count while the frame is open.
    assign sck_rise = ~cs_n_s & sck_s & ~sck_d_ff;
    assign sck_fall = ~cs_n_s & ~sck_s & sck_d_ff;
    assign cs_rise = cs_n_s & ~cs_d_ff;

    // Receive shift is MSB first; a byte closes on its eighth rise.
    assign rx_byte = {rx_ff[6:0], si_s};
    assign byte_done = sck_rise & (bit_cnt_ff == 3'h7);
    assign op_key = rx_byte & `SEPC_OP_KEY_MASK;
    assign addr_done = byte_done & addr_hi_done_ff
        & (state_ff == SEPC_ST_ADDR);
    assign is_id_op = opcode_ff[7];
    assign hw_prot = hw_protect_enable_bit_ff & ~wp_n_s;

    // Bit counter and receive register.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_ff <= 3'h0;
            rx_ff <= 8'h00;
        end else if (cs_n_s) begin
            bit_cnt_ff <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            rx_ff <= rx_byte;
        end
    end

    // Opcode decode; a busy device takes nothing but the status read.
    always_comb begin
        op_state = SEPC_ST_IGNORE;
        case (op_key)
            `SEPC_OP_SET_WL: op_state = SEPC_ST_NOARG;
            `SEPC_OP_CLR_WL: op_state = SEPC_ST_NOARG;
            `SEPC_OP_SR_RD: op_state = SEPC_ST_OUT;
            `SEPC_OP_SR_WR: op_state = SEPC_ST_IN;
            `SEPC_OP_ARR_RD: op_state = SEPC_ST_ADDR;
            `SEPC_OP_ARR_WR: op_state = SEPC_ST_ADDR;
            `SEPC_OP_ID_RD: op_state = SEPC_ST_ADDR;
            `SEPC_OP_ID_WR: op_state = SEPC_ST_ADDR;
            default: op_state = SEPC_ST_IGNORE;
        endcase
        if (busy_ff && op_key != `SEPC_OP_SR_RD) begin
            op_state = SEPC_ST_IGNORE;
        end
    end

    // Frame sequencer; select high always returns to the opcode phase.
    always_comb begin
        nxt_state = state_ff;
        if (cs_n_s) begin
            nxt_state = SEPC_ST_OPCODE;
        end else begin
            case (state_ff)
                SEPC_ST_OPCODE: begin
                    if (byte_done) begin
                        nxt_state = op_state;
                    end
                end
                SEPC_ST_NOARG: begin
                    // Extra bits spoil the byte boundary, so drop it.
                    if (sck_rise) begin
                        nxt_state = SEPC_ST_IGNORE;
                    end
                end
                SEPC_ST_ADDR: begin
                    if (addr_done) begin
                        nxt_state = opcode_ff[0] ? SEPC_ST_OUT
                            : SEPC_ST_IN;
                    end
                end
                SEPC_ST_IN: nxt_state = SEPC_ST_IN;
                SEPC_ST_OUT: nxt_state = SEPC_ST_OUT;
                SEPC_ST_IGNORE: nxt_state = SEPC_ST_IGNORE;
                default: nxt_state = SEPC_ST_IGNORE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= SEPC_ST_OPCODE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Opcode and address capture; only the low ten bits reach the array.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            opcode_ff <= 8'h00;
            addr_hi_ff <= 8'h00;
            addr_hi_done_ff <= 1'b0;
            sel_lock_ff <= 1'b0;
        end else if (cs_n_s) begin
            addr_hi_done_ff <= 1'b0;
        end else if (byte_done && state_ff == SEPC_ST_OPCODE) begin
            opcode_ff <= op_key;
        end else if (byte_done && state_ff == SEPC_ST_ADDR) begin
            addr_hi_ff <= rx_byte;
            addr_hi_done_ff <= 1'b1;
            if (addr_hi_done_ff) begin
                sel_lock_ff <= rx_byte[`SEPC_ADDR_SEL_BIT];
            end
        end
    end

    // Output source follows the opcode and the address key.
    always_comb begin
        out_src = SEPC_SRC_MEM;
        if (opcode_ff == `SEPC_OP_SR_RD) begin
            out_src = SEPC_SRC_STATUS;
        end else if (is_id_op) begin
            out_src = sel_lock_ff ? SEPC_SRC_LOCK
                : SEPC_SRC_ID;
        end
    end

    // A new output byte is loaded on the fall that starts it.
    assign out_load = sck_fall & (state_ff == SEPC_ST_OUT)
        & (bit_cnt_ff == 3'h0);
    assign in_byte = byte_done & (state_ff == SEPC_ST_IN);

    // Array pointers wrap over the whole array when reading and within
    // the 32-byte page when writing; the ID page steps its five bits.
    always_comb begin
        nxt_ptr = ptr_ff;
        if (addr_done) begin
            nxt_ptr = {addr_hi_ff[1:0], rx_byte};
        end else if (out_load && !is_id_op) begin
            nxt_ptr = ptr_ff + 10'h001;
        end else if (out_load || in_byte) begin
            nxt_ptr = {ptr_ff[9:5], ptr_ff[4:0] + 5'h01};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ptr_ff <= 10'h000;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    // Storage core requests; the core holds read data until the next
    // request, which leaves a whole byte time to fetch ahead.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_addr_ff <= 10'h000;
            id_addr_ff <= 5'h00;
            mem_rd_ff <= 1'b0;
            id_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            id_wr_ff <= 1'b0;
            wr_data_ff <= 8'h00;
        end else begin
            mem_rd_ff <= 1'b0;
            id_rd_ff <= 1'b0;
            mem_wr_ff <= 1'b0;
            id_wr_ff <= 1'b0;
            if ((addr_done && opcode_ff[0]) || out_load) begin
                mem_addr_ff <= nxt_ptr;
                id_addr_ff <= nxt_ptr[4:0];
                mem_rd_ff <= (out_src == SEPC_SRC_MEM);
                id_rd_ff <= (out_src == SEPC_SRC_ID);
            end else if (in_byte) begin
                mem_addr_ff <= ptr_ff;
                id_addr_ff <= ptr_ff[4:0];
                wr_data_ff <= rx_byte;
                // Bytes inside the protected range never reach storage.
                mem_wr_ff <= (opcode_ff == `SEPC_OP_ARR_WR) & wen_ff
                    & ~in_block(bp_ff, ptr_ff);
                id_wr_ff <= (opcode_ff == `SEPC_OP_ID_WR) & ~sel_lock_ff
                    & wen_ff & ~id_locked;
            end
        end
    end

    // Protected range lookup by block-protect pattern.
    function automatic logic in_block(input logic [1:0] bp,
                                      input logic [9:0] a);
        case (bp)
            2'b00: in_block = 1'b0;
            2'b01: in_block = (a >= `SEPC_QTR_BASE);
            2'b10: in_block = (a >= `SEPC_HALF_BASE);
            default: in_block = 1'b1;
        endcase
    endfunction : in_block

    // Data-in bookkeeping for status and lock commands.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            got_data_ff <= 1'b0;
            lock_key_ff <= 1'b0;
            sr_data_ff <= 8'h00;
        end else if (cs_n_s) begin
            got_data_ff <= 1'b0;
        end else if (in_byte) begin
            got_data_ff <= 1'b1;
            lock_key_ff <= rx_byte[`SEPC_LOCK_KEY_BIT];
            sr_data_ff <= rx_byte;
        end
    end

    // Status byte; a running cycle forces every bit high.
    always_comb begin
        status_byte = 8'h00;
        status_byte[`SEPC_SR_HW_PROTECT_ENABLE_BIT] = hw_protect_enable_bit_ff;
        status_byte[`SEPC_SR_BP_HI] = bp_ff[1];
        status_byte[`SEPC_SR_BP_LO] = bp_ff[0];
        status_byte[`SEPC_SR_WEN] = wen_ff;
        status_byte[`SEPC_SR_BUSY] = busy_ff;
        if (busy_ff) begin
            status_byte = `SEPC_SR_ALL_BUSY;
        end
    end

    always_comb begin
        case (out_src)
            SEPC_SRC_STATUS: load_byte = status_byte;
            SEPC_SRC_MEM: load_byte = mem_rd_data;
            SEPC_SRC_ID: load_byte = id_rd_data;
            default: load_byte = {7'h00, id_locked};
        endcase
    end

    // Serial output changes on falling clock edges, MSB first, and clears when select goes high.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
            tx_ff <= 8'h00;
        end else if (cs_n_s) begin
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
        end else if (sck_fall && state_ff == SEPC_ST_OUT) begin
            so_oe_ff <= 1'b1;
            if (bit_cnt_ff == 3'h0) begin
                so_ff <= load_byte[7];
                tx_ff <= {load_byte[6:0], 1'b0};
            end else begin
                so_ff <= tx_ff[7];
                tx_ff <= {tx_ff[6:0], 1'b0};
            end
        end
    end

    // Operations start only when select rises on a byte boundary.
    assign noarg_end = cs_rise & (state_ff == SEPC_ST_NOARG)
        & (bit_cnt_ff == 3'h0);
    assign commit_frame = cs_rise & (state_ff == SEPC_ST_IN)
        & (bit_cnt_ff == 3'h0) & got_data_ff;

    // Each write kind but the array write, which needs only the latch, checks its own protection before it may start.
    always_comb begin
        commit_kind = SEPC_PK_ARRAY;
        commit_go = 1'b0;
        case (opcode_ff)
            `SEPC_OP_SR_WR: begin
                commit_kind = SEPC_PK_STATUS;
                commit_go = wen_ff & ~hw_prot;
            end
            `SEPC_OP_ARR_WR: begin
                commit_kind = SEPC_PK_ARRAY;
                commit_go = wen_ff;
            end
            `SEPC_OP_ID_WR: begin
                if (sel_lock_ff) begin
                    commit_kind = SEPC_PK_LOCK;
                    commit_go = wen_ff & ~id_locked & lock_key_ff
                        & (bp_ff != 2'b11);
                end else begin
                    commit_kind = SEPC_PK_IDPAGE;
                    commit_go = wen_ff & ~id_locked;
                end
            end
            default: commit_go = 1'b0;
        endcase
        commit_go = commit_go & commit_frame;
    end

    assign cycle_end = busy_ff & prog_done;

    // Programming cycle handshake with the storage core.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy_ff <= 1'b0;
            prog_start_ff <= 1'b0;
            prog_kind_ff <= SEPC_PK_ARRAY;
            pend_sr_ff <= 8'h00;
        end else begin
            prog_start_ff <= commit_go;
            if (commit_go) begin
                busy_ff <= 1'b1;
                prog_kind_ff <= commit_kind;
                pend_sr_ff <= sr_data_ff;
            end else if (cycle_end) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // Nonvolatile status bits update when the status cycle completes;
    // they come up in the delivered state.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bp_ff <= `SEPC_BP_RESET;
            hw_protect_enable_bit_ff <= `SEPC_HW_PROTECT_ENABLE_BIT_RESET;
        end else if (cycle_end && prog_kind_ff == SEPC_PK_STATUS) begin
            bp_ff <= {pend_sr_ff[`SEPC_SR_BP_HI],
                      pend_sr_ff[`SEPC_SR_BP_LO]};
            // The pin may have dropped during the cycle; hold the bit.
            hw_protect_enable_bit_ff <= pend_sr_ff[`SEPC_SR_HW_PROTECT_ENABLE_BIT]
                | (hw_protect_enable_bit_ff & ~wp_n_s);
        end
    end

    // Write-enable latch: set by its command, cleared by disable and by
    // the end of a status or array write cycle.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wen_ff <= `SEPC_WEN_RESET;
        end else if (noarg_end && opcode_ff == `SEPC_OP_SET_WL) begin
            wen_ff <= 1'b1;
        end else if (noarg_end && opcode_ff == `SEPC_OP_CLR_WL) begin
            wen_ff <= 1'b0;
        end else if (cycle_end && (prog_kind_ff == SEPC_PK_STATUS
                     || prog_kind_ff == SEPC_PK_ARRAY)) begin
            wen_ff <= 1'b0;
        end
    end

endmodule : sepc_cmd_protect
`default_nettype wire

// [sepc_cmd_protect_assertions.sv]
// Port-level checker of the command and protection front end.
// Assumes it is bound to sepc_cmd_protect and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "sepc_regs.svh"
module sepc_cmd_protect_assertions
    import sepc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic wp_n_pin,
    input wire logic prog_done,
    input wire logic so_ff,
    input wire logic so_oe_ff,
    input wire logic [9:0] mem_addr_ff,
    input wire logic mem_rd_ff,
    input wire logic mem_wr_ff,
    input wire logic id_rd_ff,
    input wire logic id_wr_ff,
    input wire logic prog_start_ff,
    input wire logic [1:0] prog_kind_ff,
    input wire logic busy_ff,
    input wire logic wen_ff,
    input wire logic [1:0] bp_ff,
    input wire logic hw_protect_enable_bit_ff
);
    default clocking cb @(posedge clk_sys);
    endclocking
    logic hit;
    // Protected range seen by a byte load, from the block-protect pair.
    assign hit = (bp_ff == 2'h3) || (bp_ff == 2'h2 &&
        mem_addr_ff >= `SEPC_HALF_BASE) || (bp_ff == 2'h1 &&
        mem_addr_ff >= `SEPC_QTR_BASE);
    // Reset is checked without a disable so that it is seen at all.
    property p_reset;
        !rstn |-> !wen_ff && !busy_ff && bp_ff == 2'h0 && !hw_protect_enable_bit_ff;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values");
    property p_busy_ones;
        disable iff (!rstn) busy_ff && so_oe_ff |-> so_ff;
    endproperty
    a_busy_ones: assert property (p_busy_ones) else $error("busy out");
    property p_prot;
        disable iff (!rstn) mem_wr_ff |-> !hit;
    endproperty
    a_prot: assert property (p_prot) else $error("protected load");
    property p_wen;
        disable iff (!rstn) prog_start_ff |-> $past(wen_ff);
    endproperty
    a_wen: assert property (p_wen) else $error("start without wen");
    property p_hwp;
        disable iff (!rstn) prog_start_ff && prog_kind_ff == SEPC_PK_STATUS
            |-> !($past(hw_protect_enable_bit_ff) && !$past(wp_n_pin));
    endproperty
    a_hwp: assert property (p_hwp) else $error("status frozen");
    property p_clr;
        disable iff (!rstn) busy_ff && prog_done &&
            prog_kind_ff inside {SEPC_PK_ARRAY, SEPC_PK_STATUS}
            |=> !wen_ff && !busy_ff;
    endproperty
    a_clr: assert property (p_clr) else $error("latch kept");
    property p_quiet;
        disable iff (!rstn) busy_ff |->
            !(mem_rd_ff || id_rd_ff || mem_wr_ff || id_wr_ff);
    endproperty
    a_quiet: assert property (p_quiet) else $error("busy access");
    property p_hw_protect_enable_bit;
        disable iff (!rstn) $fell(hw_protect_enable_bit_ff) |-> $past(wp_n_pin);
    endproperty
    a_hw_protect_enable_bit: assert property (p_hw_protect_enable_bit) else $error("hw_protect_enable_bit dropped");
    property p_ready;
        disable iff (!rstn) $fell(busy_ff) |-> $past(prog_done);
    endproperty
    a_ready: assert property (p_ready) else $error("early ready");
    c_load: cover property (disable iff (!rstn) mem_wr_ff);
    c_done: cover property (disable iff (!rstn) busy_ff && prog_done);
    c_poll: cover property (disable iff (!rstn) busy_ff && so_oe_ff);
endmodule : sepc_cmd_protect_assertions
bind sepc_cmd_protect sepc_cmd_protect_assertions chk_u (.clk_sys, .rstn,
    .wp_n_pin, .prog_done, .so_ff, .so_oe_ff, .mem_addr_ff, .mem_rd_ff,
    .mem_wr_ff, .id_rd_ff, .id_wr_ff, .prog_start_ff, .prog_kind_ff,
    .busy_ff, .wen_ff, .bp_ff, .hw_protect_enable_bit_ff);
`default_nettype wire

// [sepc_host_model.sv]
// Behavioural serial host, mode 0, 400 ns per clock phase.
// Assumes callers start each task on a falling edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sepc_host_model (
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    // Idle link: select high, clock parked low.
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Opens a frame; the clock stays still until the first bit.
    task sel;
        cs_n = 1'b0;
        #400;
    endtask : sel
    // Swaps one byte; output is sampled just before the rising edge.
    task xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #400;
            rx[i] = so;
            sck = 1'b1;
            #400;
            sck = 1'b0;
        end
    endtask : xbyte
    // Closes at a byte boundary; released data shows a changed level.
    task desel;
        cs_n = 1'b1;
        si = ~si;
        #800;
    endtask : desel
endmodule : sepc_host_model
`default_nettype wire

// [sepc_cmd_protect_bench.sv]
// Self-checking bench of the command and protection front end.
// Assumes the host model and a small storage-core model below.
`timescale 1ns/1ps
`default_nettype none
module sepc_cmd_protect_bench;
    logic clk_sys, rstn, wp_n_pin, prog_done, id_locked;
    logic [7:0] mem_rd_data, id_rd_data, lwd, rx [6];
    logic so_ff, so_oe_ff, mem_rd_ff, mem_wr_ff, id_rd_ff, id_wr_ff;
    logic prog_start_ff, busy_ff, wen_ff, hw_protect_enable_bit_ff;
    logic [9:0] mem_addr_ff, lwa;
    logic [4:0] id_addr_ff;
    logic [7:0] wr_data_ff;
    logic [1:0] prog_kind_ff, bp_ff;
    wire cs_n, sck, si, so_pin;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0, pcnt = 0;
    // Event counters sized to the compare task's operands.
    logic [15:0] nwr = 16'h0000, nps = 16'h0000, nrd = 16'h0000;
    // Undriven output shows the inverse so a stale bit cannot pass.
    assign so_pin = so_oe_ff ? so_ff : ~so_ff;
    sepc_host_model host_u (.cs_n(cs_n), .sck(sck), .si(si), .so(so_pin));
    sepc_cmd_protect dut_u (.clk_sys(clk_sys), .rstn(rstn),
        .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si), .wp_n_pin(wp_n_pin),
        .mem_rd_data(mem_rd_data), .id_rd_data(id_rd_data),
        .id_locked(id_locked), .prog_done(prog_done), .so_ff(so_ff),
        .so_oe_ff(so_oe_ff), .mem_addr_ff(mem_addr_ff),
        .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff),
        .id_addr_ff(id_addr_ff), .id_rd_ff(id_rd_ff), .id_wr_ff(id_wr_ff),
        .wr_data_ff(wr_data_ff), .prog_start_ff(prog_start_ff),
        .prog_kind_ff(prog_kind_ff), .busy_ff(busy_ff), .wen_ff(wen_ff),
        .bp_ff(bp_ff), .hw_protect_enable_bit_ff(hw_protect_enable_bit_ff));
    // Clock of 100 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Storage core and monitors; a long busy lets polls overlap it.
    always @(negedge clk_sys) begin
        cyc++;
        prog_done <= 1'b0;
        if (mem_rd_ff === 1'b1) mem_rd_data <= mem_addr_ff[7:0] ^ 8'hA5;
        if (id_rd_ff === 1'b1) id_rd_data <= {3'h0, id_addr_ff} ^ 8'h3C;
        if (mem_rd_ff === 1'b1) nrd++;
        if (mem_wr_ff === 1'b1) begin
            nwr++;
            lwa <= mem_addr_ff;
            lwd <= wr_data_ff;
        end
        if (prog_start_ff === 1'b1) begin
            nps++;
            pcnt <= 500;
        end else if (pcnt > 0) begin
            pcnt <= pcnt - 1;
            prog_done <= (pcnt == 1);
        end
        if (cyc == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One frame of n bytes taken from the top of b.
    task frame(input logic [47:0] b, input int n);
        host_u.sel();
        for (int i = 0; i < n; i++) host_u.xbyte(b[47 - 8 * i -: 8], rx[i]);
        host_u.desel();
    endtask : frame
    task sr(input logic [7:0] exp);
        frame(48'h050000000000, 2);
        chk({8'h00, rx[1]}, {8'h00, exp});
    endtask : sr
    // Bounded wait for ready, then a short gap.
    task idle;
        for (int i = 0; i < 2000 && busy_ff !== 1'b0; i++) @(negedge clk_sys);
        chk({15'h0000, busy_ff}, 16'h0000);
        repeat (5) @(negedge clk_sys);
    endtask : idle
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    // Main sequence; every frame starts on a falling clock edge.
    initial begin
        rstn = 1'b0;
        wp_n_pin = 1'b1;
        id_locked = 1'b0;
        prog_done = 1'b0;
        mem_rd_data = 8'h00;
        id_rd_data = 8'h00;
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (5) @(negedge clk_sys);
        sr(8'h00);
        frame(48'h060000000000, 1);
        sr(8'h02);
        frame(48'h018C00000000, 2);
        frame(48'h050000000000, 3);
        chk({rx[1], rx[2]}, 16'hFFFF);
        idle();
        sr(8'h8C);
        frame(48'h060000000000, 1);
        frame(48'h020100550000, 4);
        idle();
        chk(nwr, 16'h0);
        chk(nps, 16'h2);
        wp_n_pin = 1'b0;
        frame(48'h060000000000, 1);
        frame(48'h010000000000, 2);
        repeat (10) @(negedge clk_sys);
        sr(8'h8E);
        chk(nps, 16'h2);
        wp_n_pin = 1'b1;
        repeat (5) @(negedge clk_sys);
        frame(48'h010400000000, 2);
        idle();
        sr(8'h04);
        chk({14'h0000, prog_kind_ff}, 16'h0001);
        frame(48'h060000000000, 1);
        frame(48'h02FEF03C0000, 4);
        idle();
        chk({6'h00, lwa}, 16'h02F0);
        chk({8'h00, lwd}, 16'h003C);
        chk({14'h0000, prog_kind_ff}, 16'h0000);
        frame(48'h550200107700, 5);
        chk(nwr, 16'h1);
        chk(nps, 16'h4);
        frame(48'h060000000000, 1);
        frame(48'h020300110000, 4);
        frame(48'h030010000000, 4);
        chk(nrd, 16'h0);
        sr(8'hFF);
        idle();
        chk(nwr, 16'h1);
        sr(8'h04);
        frame(48'h037C05000000, 5);
        chk({rx[3], rx[4]}, 16'hA0A3);
        frame(48'h060000000000, 1);
        frame(48'h040000000000, 1);
        sr(8'h04);
        frame(48'h020010770000, 4);
        repeat (10) @(negedge clk_sys);
        chk(nps, 16'h5);
        frame(48'h8B0005000000, 4);
        // One data byte loaded, so the index has stepped to the next byte.
        chk({11'h000, id_addr_ff}, 16'h0006);
        chk({8'h00, rx[3]}, 16'h0039);
        report_and_stop();
    end
endmodule : sepc_cmd_protect_bench
`default_nettype wire
